// file: ciq_top.sv
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ciq_cfg.svh"
module ciq_top #(
    parameter int SEC_SAMPLES = `CIQ_SEC_SAMPLES // Samples per second
) (
    input wire logic clk_i, // 20 MHz clock
    input wire logic rst_i, // Sync reset, high
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write
    input wire logic [11:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic lnk_clk_i, // Playback sample clock
    input wire logic [15:0] lnk_sign_i, // Sign bits
    input wire logic [15:0] lnk_mag_i, // Magnitude bits
    input wire logic [15:0] lnk_vld_i, // Validity bits
    output logic smp_clk_o, // Sample clock to playback
    output logic tick_o, // Second tick to playback
    output logic out_stb_o, // Kept sample pulse
    output logic [15:0] out_sign_o, // Kept sign
    output logic [15:0] out_mag_o, // Kept magnitude
    output logic [15:0] out_en_o // Correlation enable
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [48:0] s1, s2; // Link synchroniser stages
    logic lnk_d; // Delayed synced clock
    logic ev; // Sample event
    logic [15:0] sgn, mag, vld; // Synced sample bits
    logic [4:0] ctrl, next_ctrl; // Control register
    logic [2:0] rate; // Shift rate code
    logic [6:0] dec, next_dec; // Decimation count
    logic [31:0] sec, next_sec; // Samples this second
    logic tick; // Internal second pulse
    logic next_tick_o;
    logic [2:0] sdiv, next_sdiv; // Sample clock divider
    logic next_smp_clk;
    logic [15:0] gopen; // Gate open per channel
    logic [15:0] en; // Valid and gated
    logic [15:0] mag_use; // Magnitude after mode
    logic next_out_stb;
    logic [15:0] next_out_sign, next_out_mag, next_out_en;
    ciq_pkg::ciq_cnt_t pend_g [16][8]; // Gate shadow words
    ciq_pkg::ciq_cnt_t act_g [16][8]; // Gate active words
    ciq_pkg::ciq_cnt_t next_pend_g [16][8];
    ciq_pkg::ciq_cnt_t next_act_g [16][8];
    logic [11:0] pend_d [4], act_d [4]; // Detector setup
    logic [11:0] next_pend_d [4], next_act_d [4];
    logic [31:0] lo [4], next_lo [4]; // LO phase
    ciq_pkg::ciq_acc_t acc_c [4], acc_s [4]; // Running sums
    ciq_pkg::ciq_acc_t next_acc_c [4], next_acc_s [4];
    ciq_pkg::ciq_acc_t res_c [4], res_s [4]; // Per-second results
    ciq_pkg::ciq_acc_t next_res_c [4], next_res_s [4];
    logic req, wr; // Fresh request, fresh write
    logic [31:0] rdat, next_ack_dat;
    logic next_ack;

    // Merge write data into an old word by byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[8*b +: 8] = dat[8*b +: 8];
        end
        return r;
    endfunction

    // True when the address lies in the gate window block
    function automatic logic is_gate(input logic [11:0] a);
        return a[11:9] == `CIQ_ADR_GATE >> 9;
    endfunction

    // ****************************************
    // Link synchroniser
    // ****************************************
    // Clock and data all pass two flops before any use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            lnk_d <= 1'b0;
        end else begin
            s1 <= {lnk_clk_i, lnk_vld_i, lnk_mag_i, lnk_sign_i};
            s2 <= s1;
            lnk_d <= s2[48];
        end
    end
    // One event per rising link clock edge, never buffered
    assign ev = s2[48] & ~lnk_d; // [R6] [R18]
    assign sgn = s2[15:0];
    assign mag = s2[31:16]; // [R1]
    assign vld = s2[47:32];
    assign rate = ctrl[`CIQ_CTRL_RATE +: 3];

    // ****************************************
    // Gate generators
    // ****************************************
    genvar c;
    generate
        for (c = 0; c < 16; c++) begin : g_ch
            ciq_gate_if gi ();
            assign gi.step = ev; // [R9]
            assign gi.tick = tick;
            // Offset is read only at the tick, as the shadow goes live
            assign gi.cfg = {act_g[c][0], pend_g[c][1], act_g[c][6],
                act_g[c][4], act_g[c][2], act_g[c][7], act_g[c][5],
                act_g[c][3]}; // [R11] [R21]
            assign gopen[c] = gi.open;
            ciq_gate u_gate (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .g (gi.gen)
            );
        end
    endgenerate

    // Gate closed, with gating enabled, equals an invalid sample
    assign en = vld & (gopen | {16{~ctrl[`CIQ_CTRL_GATEEN]}}); // [R12]
    // Single-bit mode drops magnitude and keeps sign
    assign mag_use = ctrl[`CIQ_CTRL_ONEBIT] ? 16'h0000 : mag; // [R2]

    // ****************************************
    // Timing: second tick, sample clock, decimation
    // ****************************************
    always_comb begin
        next_sec = sec;
        tick = 1'b0;
        next_tick_o = tick_o;
        if (ev) begin
            next_tick_o = 1'b0;
            if (sec >= SEC_SAMPLES[31:0] - 32'h1) begin
                next_sec = '0;
                tick = 1'b1; // [R19] [R17]
                next_tick_o = 1'b1;
            end else begin
                next_sec = sec + 32'h1;
            end
        end
        // Divider gives a free-running clock toward the playback unit
        next_sdiv = sdiv + 3'h1;
        next_smp_clk = smp_clk_o;
        if (sdiv == `CIQ_SCLK_HALF - 3'h1) begin
            next_sdiv = '0;
            next_smp_clk = ~smp_clk_o; // [R19]
        end
        // Keep one sample in 2**rate; the rest are simply lost
        next_dec = ev ? dec + 7'h1 : dec;
        next_out_stb = 1'b0;
        next_out_sign = out_sign_o;
        next_out_mag = out_mag_o;
        next_out_en = out_en_o;
        if (ev && ((dec & ((7'h1 << rate) - 7'h1)) == 7'h0)) begin // [R7]
            next_out_stb = 1'b1; // [R8]
            next_out_sign = sgn; // [R3]
            next_out_mag = mag_use;
            next_out_en = en; // [R4] [R5] [R20]
        end
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec <= '0;
            tick_o <= 1'b0;
            sdiv <= '0;
            smp_clk_o <= 1'b0;
            dec <= '0;
            out_stb_o <= 1'b0;
            out_sign_o <= '0;
            out_mag_o <= '0;
            out_en_o <= '0;
        end else begin
            sec <= next_sec;
            tick_o <= next_tick_o;
            sdiv <= next_sdiv;
            smp_clk_o <= next_smp_clk;
            dec <= next_dec;
            out_stb_o <= next_out_stb;
            out_sign_o <= next_out_sign;
            out_mag_o <= next_out_mag;
            out_en_o <= next_out_en;
        end
    end

    // ****************************************
    // Tone detectors
    // ****************************************
    // Raw samples ahead of any delay stage feed the detectors
    always_comb begin
        logic [3:0] ch;
        logic signed [2:0] v;
        logic [7:0] ph;
        ch = '0;
        v = '0;
        ph = '0;
        for (int d = 0; d < 4; d++) begin
            next_lo[d] = lo[d];
            next_acc_c[d] = acc_c[d];
            next_acc_s[d] = acc_s[d];
            next_res_c[d] = res_c[d];
            next_res_s[d] = res_s[d];
            // Channel picked among the four of this detector's group
            ch = {d[1:0], act_d[d][`CIQ_DET_SEL +: 2]}; // [R15]
            // Sign 1 positive; magnitude 1 is the outer level
            v = mag_use[ch] ? 3'sd3 : 3'sd1; // [R3]
            if (!sgn[ch]) v = -v;
            if (!en[ch]) v = 3'sd0; // [R14]
            ph = lo[d][31:24]; // [R15]
            if (ev) begin
                next_lo[d] = lo[d] + 32'(act_d[d][9:0] * `CIQ_LO_INC);
                next_acc_c[d] = acc_c[d] +
                    ((ph[7] ^ ph[6]) ? -32'(v) : 32'(v)); // [R13]
                next_acc_s[d] = acc_s[d] +
                    (ph[7] ? -32'(v) : 32'(v));
            end
            // Latch and restart on the second boundary only
            if (tick) begin
                next_res_c[d] = next_acc_c[d]; // [R17]
                next_res_s[d] = next_acc_s[d];
                next_acc_c[d] = '0;
                next_acc_s[d] = '0;
                next_lo[d] = '0;
            end
        end
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int d = 0; d < 4; d++) begin
                lo[d] <= '0;
                acc_c[d] <= '0;
                acc_s[d] <= '0;
                res_c[d] <= '0;
                res_s[d] <= '0;
            end
        end else begin
            lo <= next_lo;
            acc_c <= next_acc_c;
            acc_s <= next_acc_s;
            res_c <= next_res_c;
            res_s <= next_res_s;
        end
    end

    // ****************************************
    // Register file and shadow loading
    // ****************************************
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;

    always_comb begin
        next_ctrl = ctrl;
        next_pend_g = pend_g;
        next_act_g = act_g;
        next_pend_d = pend_d;
        next_act_d = act_d;
        // Control takes effect at once
        if (wr && wb_adr_i == `CIQ_ADR_CTRL) begin
            next_ctrl = 5'(merge({27'h0, ctrl}, wb_dat_i, wb_sel_i)); // [R7]
        end
        // Setup goes to shadow first
        if (wr && wb_adr_i[11:4] == `CIQ_ADR_DET >> 4) begin
            next_pend_d[wb_adr_i[3:2]] = 12'(merge(
                {20'h0, pend_d[wb_adr_i[3:2]]}, wb_dat_i, wb_sel_i));
        end
        if (wr && is_gate(wb_adr_i)) begin
            next_pend_g[wb_adr_i[8:5]][wb_adr_i[4:2]] = 28'(merge(
                {4'h0, pend_g[wb_adr_i[8:5]][wb_adr_i[4:2]]},
                wb_dat_i, wb_sel_i));
        end
        // Shadow moves to active only at the second tick
        if (tick) begin
            next_act_g = pend_g; // [R21]
            next_act_d = pend_d; // [R16] [R21]
        end
        // Read mux; unmapped reads give zero
        rdat = '0;
        if (wb_adr_i == `CIQ_ADR_CTRL) begin
            rdat = {27'h0, ctrl};
        end else if (wb_adr_i == `CIQ_ADR_STAT) begin
            rdat = sec;
        end else if (wb_adr_i[11:4] == `CIQ_ADR_DET >> 4) begin
            rdat = {20'h0, pend_d[wb_adr_i[3:2]]};
        end else if (wb_adr_i[11:5] == `CIQ_ADR_RES >> 5) begin
            rdat = wb_adr_i[2] ? res_s[wb_adr_i[4:3]] :
                res_c[wb_adr_i[4:3]];
        end else if (is_gate(wb_adr_i)) begin
            rdat = {4'h0, pend_g[wb_adr_i[8:5]][wb_adr_i[4:2]]};
        end
        next_ack = req;
        next_ack_dat = req ? rdat : wb_dat_o;
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `CIQ_CTRL_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            for (int i = 0; i < 16; i++) begin
                for (int j = 0; j < 8; j++) begin
                    pend_g[i][j] <= '0;
                    act_g[i][j] <= '0;
                end
            end
            for (int d = 0; d < 4; d++) begin
                pend_d[d] <= '0;
                act_d[d] <= '0;
            end
        end else begin
            ctrl <= next_ctrl;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_ack_dat;
            pend_g <= next_pend_g;
            act_g <= next_act_g;
            pend_d <= next_pend_d;
            act_d <= next_act_d;
        end
    end
endmodule

// file: ciq_cfg.svh
// Function
// (R1) Playback always delivers two-bit samples
// (R2) One-bit mode ignores the magnitude bit
// (R3) Samples are sign plus magnitude coded
// (R4) Validity bit admits or excludes each sample
// (R5) Validity applied per sample, no run assumptions
// (R6) Accept one sample per channel per period
// (R7) Shift rate halvings from full to 1/128
// (R8) Surplus samples dropped, never buffered
// (R9) Sixteen gate generators with programmable period
// (R10) Up to three windows per gate period
// (R11) Per-channel window offset for dispersion
// (R12) Outside open window means sample invalid
// (R13) Tone detection uses undelayed input samples
// (R14) Invalid samples blanked from tone sums
// (R15) Four detectors, channel, tone, quantized LO
// (R16) Detector selection changes only at tick
// (R17) Detector integration spans exactly one second
// (R18) Playback sends sixteen channels of bits
// (R19) Device drives sample clock and second tick
// (R20) Enable is validity AND gate, registered
// (R21) Gate and detector setup load at tick
`ifndef CIQ_CFG_SVH
`define CIQ_CFG_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define CIQ_ADR_CTRL 12'h000
`define CIQ_ADR_STAT 12'h004
`define CIQ_ADR_DET 12'h010
`define CIQ_ADR_RES 12'h020
`define CIQ_ADR_GATE 12'h400

// ****************************************
// Control fields and reset value, detector select field
// ****************************************
`define CIQ_CTRL_ONEBIT 0
`define CIQ_CTRL_RATE 1
`define CIQ_CTRL_GATEEN 4
`define CIQ_CTRL_RST 5'h00
`define CIQ_DET_SEL 10

// ****************************************
// Timing
// ****************************************
`define CIQ_SMP_RATE 16000000
`define CIQ_TICK_S 1
`define CIQ_SEC_SAMPLES (`CIQ_SMP_RATE * `CIQ_TICK_S)
`define CIQ_SCLK_HALF 3'h4
`define CIQ_LO_STEP_HZ 10000
`define CIQ_LO_INC ((64'h1_0000_0000 * `CIQ_LO_STEP_HZ + \
    `CIQ_SMP_RATE / 2) / `CIQ_SMP_RATE)

`endif

// file: ciq_pkg.sv
package ciq_pkg;
    // Gate counts in samples, 10 s at 16 Msample/s fits
    typedef logic [27:0] ciq_cnt_t;
    // Signed tone accumulator
    typedef logic signed [31:0] ciq_acc_t;
    // Tone code in 10 kHz steps
    typedef logic [9:0] ciq_tone_t;
    // Per-channel gate setup
    typedef struct packed {
        ciq_cnt_t period;
        ciq_cnt_t offset;
        ciq_cnt_t [2:0] wstart;
        ciq_cnt_t [2:0] wlen;
    } ciq_gate_t;
endpackage

// file: ciq_gate_if.sv
`timescale 1ns/100ps
interface ciq_gate_if;
    logic step; // One sample event
    logic tick; // One-second boundary
    ciq_pkg::ciq_gate_t cfg; // Active setup
    logic open; // Window open now
    modport gen (input step, input tick, input cfg, output open);
    modport ctl (output step, output tick, output cfg, input open);
endinterface

// file: ciq_gate.sv
`timescale 1ns/100ps
module ciq_gate (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset
    ciq_gate_if.gen g // Gate control link
);
    ciq_pkg::ciq_cnt_t phase; // Position within period
    ciq_pkg::ciq_cnt_t next_phase;
    logic [2:0] hit; // Per-window hit

    // ****************************************
    // Window compare
    // ****************************************
    // Zero length disables a window; overlap is software's duty
    genvar w;
    generate
        for (w = 0; w < 3; w++) begin : g_win
            assign hit[w] = (g.cfg.wlen[w] != '0) &&
                (phase >= g.cfg.wstart[w]) &&
                (phase - g.cfg.wstart[w] < g.cfg.wlen[w]); // [R10]
        end
    endgenerate
    assign g.open = |hit;

    // ****************************************
    // Phase counter
    // ****************************************
    // Tick realigns to the offset so channels differ by dispersion
    always_comb begin
        next_phase = phase;
        if (g.tick) begin
            next_phase = g.cfg.offset; // [R11]
        end else if (g.step) begin
            if (phase + 28'h1 >= g.cfg.period) begin
                next_phase = '0; // [R9]
            end else begin
                next_phase = phase + 28'h1;
            end
        end
    end

    // Register only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= '0;
        end else begin
            phase <= next_phase;
        end
    end
endmodule

// file: ciq_top_props.sv
`timescale 1ns/100ps
module ciq_top_chk #(
    parameter int SEC_SAMPLES = 20 // Samples per second
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [11:0] wb_adr_i, // Address
    input wire logic [3:0] wb_sel_i, // Lanes
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic lnk_clk_i, // Link clock
    input wire logic [15:0] lnk_sign_i, // Sign in
    input wire logic [15:0] lnk_mag_i, // Magnitude in
    input wire logic [15:0] lnk_vld_i, // Validity in
    input wire logic smp_clk_o, // Sample clock
    input wire logic tick_o, // Second tick
    input wire logic out_stb_o, // Kept strobe
    input wire logic [15:0] out_sign_o, // Sign out
    input wire logic [15:0] out_mag_o, // Magnitude out
    input wire logic [15:0] out_en_o // Enable out
);
    // ****
    // One domain, so clock and reset are set once
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Bus request not answered next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");
    chk_smp_high: assert property (
        $rose(smp_clk_o) |-> smp_clk_o[*4] ##1 !smp_clk_o)
        else $error("Sample clock high phase not 4 cycles");
    chk_smp_low: assert property (
        $fell(smp_clk_o) |-> !smp_clk_o[*4] ##1 smp_clk_o)
        else $error("Sample clock low phase not 4 cycles");
    chk_stb_gap: assert property (
        out_stb_o |=> !out_stb_o[*6])
        else $error("Kept samples closer than link rate");
    chk_stb_link: assert property ($rose(out_stb_o) |->
        $past(lnk_clk_i, 2) || $past(lnk_clk_i, 3) || $past(lnk_clk_i, 4))
        else $error("Kept strobe without a link clock edge");
    chk_out_hold: assert property (!out_stb_o |-> $stable(out_sign_o) &&
        $stable(out_mag_o) && $stable(out_en_o))
        else $error("Sample outputs moved without strobe");
    chk_en_valid: assert property (out_stb_o |->
        (out_en_o & ~($past(lnk_vld_i, 3) | $past(lnk_vld_i, 4))) == 16'h0)
        else $error("Enable set for an invalid sample");
    chk_tick_len: assert property (
        $rose(tick_o) |-> tick_o[*4] ##[1:8] !tick_o)
        else $error("Second tick length wrong");
    // Main traffic seen at all
    cov_tick: cover property ($rose(tick_o));
    cov_kept: cover property (out_stb_o && out_en_o != 16'h0);
    cov_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind ciq_top ciq_top_chk #(.SEC_SAMPLES(SEC_SAMPLES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lnk_clk_i(lnk_clk_i), .lnk_sign_i(lnk_sign_i), .lnk_mag_i(lnk_mag_i),
    .lnk_vld_i(lnk_vld_i), .smp_clk_o(smp_clk_o), .tick_o(tick_o),
    .out_stb_o(out_stb_o), .out_sign_o(out_sign_o), .out_mag_o(out_mag_o),
    .out_en_o(out_en_o));

// file: ciq_play.sv
`timescale 1ns/100ps
// ****
// Playback unit model, 400 ns sample clock
// ****
module ciq_play (
    output logic lnk_clk_o, // Sample clock
    output logic [15:0] sign_o, // Sign bits
    output logic [15:0] mag_o, // Magnitude bits
    output logic [15:0] vld_o, // Validity bits
    output logic [47:0] cap_o // Sample at last rise
);
    logic [7:0] n; // Sample number
    // Data moves mid-period so it is steady at each rise
    initial begin
        lnk_clk_o = 1'b0;
        n = 8'h00;
        cap_o = 48'h0;
        forever begin
            sign_o = {n, ~n}; // Sixteen channels per sample
            mag_o = {~n, n} ^ 16'h3c3c; // Two bits always
            vld_o = n[0] ? 16'hffff : 16'h0f0f; // Flips per sample
            #200 lnk_clk_o = 1'b1;
            cap_o = {sign_o, mag_o, vld_o};
            #200 lnk_clk_o = 1'b0;
            n = n + 8'h01;
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
    // ****
    // Signals, short second to keep the run small
    // ****
    localparam int SECN = 20; // Samples per second here
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic lnk_clk, smp_clk_o, tick_o, out_stb_o;
    logic [15:0] l_sign, l_mag, l_vld, out_sign_o, out_mag_o, out_en_o;
    logic [47:0] cap; // Sample the model last presented
    int err_count, checks_done, cnt, c0, c1, i;
    logic [7:0] p0, p1; // Enable patterns after the tick
    // Gate words: ch0 period 4 one window, ch1 period 8 three windows
    logic [27:0] gv [12] = '{28'h4, 28'h0, 28'h0, 28'h2, 28'h8, 28'h3,
        28'h0, 28'h1, 28'h2, 28'h1, 28'h4, 28'h1};
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    ciq_top #(.SEC_SAMPLES(SECN)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .lnk_clk_i(lnk_clk), .lnk_sign_i(l_sign), .lnk_mag_i(l_mag),
        .lnk_vld_i(l_vld), .smp_clk_o(smp_clk_o), .tick_o(tick_o),
        .out_stb_o(out_stb_o), .out_sign_o(out_sign_o),
        .out_mag_o(out_mag_o), .out_en_o(out_en_o));
    ciq_play far (.lnk_clk_o(lnk_clk), .sign_o(l_sign), .mag_o(l_mag),
        .vld_o(l_vld), .cap_o(cap));
    // ****
    // Reporting and compares
    // ****
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        err_count++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) fail($sformatf("got %h exp %h", got, exp));
    endtask
    task automatic cmp_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) fail($sformatf("count %0d exp %0d", got, exp));
    endtask
    // Classic cycle: hold until ack, take data there, then drop
    task automatic wb(input logic we, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            fail("no ack");
            tally_and_finish;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        cmp_val(rd, e);
    endtask
    // Bounded wait for the next kept sample
    task automatic wait_stb;
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (out_stb_o !== 1'b1 && k < 40);
        if (out_stb_o !== 1'b1) begin
            fail("no sample");
            tally_and_finish;
        end
    endtask
    // Kept samples against the model's last presented sample
    task automatic check_smp(input logic one, input logic [15:0] gm);
        repeat (4) begin
            wait_stb;
            cmp_val(32'(out_sign_o), 32'(cap[47:32]));
            cmp_val(32'(out_mag_o), one ? 32'h0 : 32'(cap[31:16]));
            cmp_val(32'(out_en_o), 32'(cap[15:0] & gm));
        end
    endtask
    // Counts strobes up to the next rising tick
    task automatic to_tick(output int n);
        int k;
        logic low;
        n = 0;
        k = 0;
        low = 1'b0;
        do begin
            @(posedge clk_i);
            k++;
            if (out_stb_o === 1'b1) n++;
            if (tick_o !== 1'b1) low = 1'b1;
        end while (!(low && tick_o === 1'b1) && k < 4000);
        if (k >= 4000) begin
            fail("no tick");
            tally_and_finish;
        end
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        err_count = 0;
        checks_done = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(12'h000, 32'h0);
        rdc(12'h300, 32'h0);
        wr(12'h440, 32'hffff_ffff);
        rdc(12'h440, 32'h0fff_ffff);
        wb(1'b1, 12'h014, 32'h0000_0fff, 4'h1);
        rdc(12'h014, 32'h0000_00ff);
        $display("test registers done");
        check_smp(1'b0, 16'hffff);
        wr(12'h000, 32'h1);
        wait_stb;
        check_smp(1'b1, 16'hffff);
        $display("test sample path done");
        for (i = 0; i < 8; i++) begin
            wr(12'h000, 32'(i << 1));
            cnt = 0;
            repeat (1024) begin
                @(posedge clk_i);
                if (out_stb_o === 1'b1) cnt++;
            end
            cmp_cnt(cnt, 128 >> i);
        end
        $display("test shift rate done");
        wr(12'h000, 32'h0);
        to_tick(cnt);
        to_tick(cnt);
        cmp_cnt(cnt, SECN);
        rdc(12'h020, 32'hffff_ffec);
        rdc(12'h024, 32'hffff_ffec);
        wb(1'b0, 12'h004, 32'h0, 4'hf);
        cmp_cnt((rd < 32'(SECN)) === 1'b1 ? 1 : 0, 1);
        $display("test second done");
        wr(12'h000, 32'h10);
        wait_stb;
        check_smp(1'b0, 16'h0000);
        to_tick(cnt);
        to_tick(cnt);
        rdc(12'h020, 32'h0);
        rdc(12'h024, 32'h0);
        to_tick(cnt);
        for (i = 0; i < 12; i++) begin
            wr(i < 4 ? 12'h400 + 12'(4 * i) : 12'h410 + 12'(4 * i),
                32'(gv[i]));
        end
        check_smp(1'b0, 16'h0000);
        rdc(12'h424, 32'h3);
        to_tick(cnt);
        c0 = 0;
        c1 = 0;
        p0 = 8'h00;
        p1 = 8'h00;
        repeat (8) begin
            wait_stb;
            if (out_en_o[0] === 1'b1) c0++;
            if (out_en_o[1] === 1'b1) c1++;
            p0 = {p0[6:0], out_en_o[0]};
            p1 = {p1[6:0], out_en_o[1]};
        end
        cmp_cnt(c0, 4);
        cmp_cnt(c1, 3);
        cmp_val(32'(p0), 32'h0000_00cc);
        cmp_val(32'(p1), 32'h0000_0045);
        cmp_val(32'(out_en_o & 16'hfffc), 32'h0);
        $display("test gating done");
        tally_and_finish;
    end
endmodule
